// File: hw/sied_store_decode.sv
`timescale 1ns/1ps
`include "sied_cfg.svh"
// Overview of operation
// - Decode indexed integer doubleword store, bit 31 zero
// - Integer indexed store writes base plus index
// - Integer doubleword store illegal on 32-bit
// - Opcode 54 stores float doubleword at displacement
// - Sign-extend displacement; base zero uses it alone
// - Float stores never touch status or CR0
// - Opcode 55 is displacement form with update
// - Update base only if nonzero and no fault
// - Extended 759 is indexed float store with update
// - Indexed: base plus index, or index alone
// - Extended 727 is indexed float store
// - Extended 983 stores low float word unconverted
// - Single-precision source may give undefined word
// - Word store optional; absent means unsupported
module sied_store_decode #(
  parameter int ADDR_W = 64
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  input wire logic insn_valid,
  output logic insn_ready,
  input wire logic [31:0] insn,
  input wire logic impl_64bit,
  input wire logic word_store_present,
  output logic [4:0] int_source_reg,
  output logic [4:0] fp_source_reg,
  output logic [4:0] base_reg_field,
  output logic [4:0] index_reg_field,
  input wire logic [63:0] int_src_value,
  input wire logic [63:0] fp_src_value,
  input wire logic fp_src_single,
  input wire logic [ADDR_W-1:0] base_value,
  input wire logic [ADDR_W-1:0] index_value,
  output logic st_valid,
  input wire logic st_ready,
  output logic [ADDR_W-1:0] st_addr,
  output logic [63:0] st_data,
  output logic [3:0] st_size,
  output logic st_data_undefined,
  input wire logic mem_resp_valid,
  input wire logic mem_align_int,
  input wire logic mem_dsi_int,
  output logic wb_valid,
  output logic [4:0] wb_reg,
  output logic [ADDR_W-1:0] wb_data,
  output logic illegal_insn,
  output logic unsupported_insn
);

  // Base field zero means literal zero, not register contents
  function automatic logic [ADDR_W-1:0] ea_calc(input logic base_zero,
      input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] offset);
    ea_calc = base_zero ? offset : base + offset;
  endfunction : ea_calc

  logic [5:0] op;
  logic [9:0] xo;
  logic base_zero;
  logic is_int_dw, is_fp_d, is_fp_du, is_fp_dux, is_fp_dx, is_fp_w;
  logic is_update, is_disp, recognised;
  logic [ADDR_W-1:0] disp_ext, offset, ea;
  logic [63:0] data_sel;
  logic accept;

  // Field extraction doubles as register file read addresses
  assign op = insn[`SIED_OP_HI:`SIED_OP_LO];
  assign xo = insn[`SIED_XO_HI:`SIED_XO_LO];
  assign int_source_reg = insn[`SIED_SRC_HI:`SIED_SRC_LO];
  assign fp_source_reg = insn[`SIED_SRC_HI:`SIED_SRC_LO];
  assign base_reg_field = insn[`SIED_BASE_HI:`SIED_BASE_LO];
  assign index_reg_field = insn[`SIED_IDX_HI:`SIED_IDX_LO];
  assign base_zero = (base_reg_field == 5'h00);

  // Opcode match; bit 31 is only checked where it is not reserved
  assign is_int_dw = (op == `SIED_OP_XFORM) && (xo == `SIED_XO_INT_DW_IDX)
      && !insn[0];
  assign is_fp_d = (op == `SIED_OP_FP_DISP);
  assign is_fp_du = (op == `SIED_OP_FP_DISP_UPD);
  assign is_fp_dux = (op == `SIED_OP_XFORM) && (xo == `SIED_XO_FP_DW_IDX_UPD);
  assign is_fp_dx = (op == `SIED_OP_XFORM) && (xo == `SIED_XO_FP_DW_IDX);
  assign is_fp_w = (op == `SIED_OP_XFORM) && (xo == `SIED_XO_FP_WORD_IDX);
  assign is_update = is_fp_du || is_fp_dux;
  assign is_disp = is_fp_d || is_fp_du;
  assign recognised = is_int_dw || is_fp_d || is_fp_du || is_fp_dux || is_fp_dx || is_fp_w;

  // Address generation shared by displacement and indexed forms
  assign disp_ext = ADDR_W'($signed(insn[`SIED_DISP_HI:`SIED_DISP_LO]));
  assign offset = is_disp ? disp_ext : index_value;
  assign ea = ea_calc(base_zero, base_value, offset);

  // Word form takes the low half raw, no format conversion
  assign data_sel = is_int_dw ? int_src_value
      : is_fp_w ? {32'h0, fp_src_value[31:0]} : fp_src_value;

  sied_pkg::sied_state_t state, next_state;
  logic [ADDR_W-1:0] next_st_addr;
  logic [63:0] next_st_data;
  logic [3:0] next_st_size;
  logic next_st_data_undefined;
  logic upd_en, next_upd_en;
  logic next_wb_valid;
  logic [4:0] next_wb_reg;
  logic [ADDR_W-1:0] next_wb_data;
  logic next_illegal_insn, next_unsupported_insn;

  // Handshakes are combinational from the state
  assign insn_ready = (state == sied_pkg::SIED_IDLE);
  assign st_valid = (state == sied_pkg::SIED_REQ);
  assign accept = insn_valid && insn_ready && clock_en;

  // Sequencer next-state; no status or CR0 outputs exist here
  always_comb begin
    next_state = state;
    next_st_addr = st_addr;
    next_st_data = st_data;
    next_st_size = st_size;
    next_st_data_undefined = st_data_undefined;
    next_upd_en = upd_en;
    next_wb_reg = wb_reg;
    next_wb_data = wb_data;
    next_wb_valid = 1'b0;
    next_illegal_insn = 1'b0;
    next_unsupported_insn = 1'b0;
    case (state)
      sied_pkg::SIED_IDLE: begin
        if (insn_valid) begin
          if (is_int_dw && !impl_64bit) begin
            next_illegal_insn = 1'b1;
          end else if ((is_fp_w && !word_store_present) || !recognised) begin
            next_unsupported_insn = 1'b1;
          end else begin
            next_state = sied_pkg::SIED_REQ;
            next_st_addr = ea;
            next_st_data = data_sel;
            next_st_size = is_fp_w ? `SIED_SIZE_WORD : `SIED_SIZE_DW;
            // Value is stored anyway; the flag lets the core trace it
            next_st_data_undefined = is_fp_w && fp_src_single;
            next_upd_en = is_update && !base_zero;
            next_wb_reg = base_reg_field;
          end
        end
      end
      sied_pkg::SIED_REQ: begin
        // Request held steady until memory takes it
        if (st_ready) begin
          next_state = sied_pkg::SIED_RESP;
        end
      end
      sied_pkg::SIED_RESP: begin
        // Base update waits for the access outcome, faults cancel it
        if (mem_resp_valid) begin
          next_state = sied_pkg::SIED_IDLE;
          if (upd_en && !mem_align_int && !mem_dsi_int) begin
            next_wb_valid = 1'b1;
            next_wb_data = st_addr;
          end
        end
      end
      default: begin
        next_state = sied_pkg::SIED_IDLE;
      end
    endcase
  end

  // State registers; clock_en low freezes everything
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= sied_pkg::SIED_IDLE;
      st_addr <= ADDR_W'(`SIED_ADDR_RST);
      st_data <= `SIED_DATA_RST;
      st_size <= `SIED_SIZE_DW;
      st_data_undefined <= 1'b0;
      upd_en <= 1'b0;
      wb_valid <= 1'b0;
      wb_reg <= 5'h00;
      wb_data <= ADDR_W'(`SIED_ADDR_RST);
      illegal_insn <= 1'b0;
      unsupported_insn <= 1'b0;
    end else if (clock_en) begin
      state <= next_state;
      st_addr <= next_st_addr;
      st_data <= next_st_data;
      st_size <= next_st_size;
      st_data_undefined <= next_st_data_undefined;
      upd_en <= next_upd_en;
      wb_valid <= next_wb_valid;
      wb_reg <= next_wb_reg;
      wb_data <= next_wb_data;
      illegal_insn <= next_illegal_insn;
      unsupported_insn <= next_unsupported_insn;
    end
  end

  // Checks on decode, address and update behaviour
  property p_illegal_32bit;
    @(posedge clock) disable iff (!reset_n)
    accept && is_int_dw && !impl_64bit |=> illegal_insn && !st_valid;
  endproperty
  a_illegal_32bit: assert property (p_illegal_32bit)
    else $error("32-bit dw store not trapped");

  property p_int_dw_store;
    @(posedge clock) disable iff (!reset_n)
    accept && is_int_dw && impl_64bit |=> st_valid && st_size == `SIED_SIZE_DW
        && st_data == $past(int_src_value);
  endproperty
  a_int_dw_store: assert property (p_int_dw_store)
    else $error("Integer dw store wrong");

  property p_disp_base_zero;
    @(posedge clock) disable iff (!reset_n)
    accept && is_fp_d && base_zero |=>
        st_addr == ADDR_W'($signed($past(insn[15:0])));
  endproperty
  a_disp_base_zero: assert property (p_disp_base_zero)
    else $error("Displacement EA wrong");

  property p_disp_add;
    @(posedge clock) disable iff (!reset_n)
    accept && is_fp_d && !base_zero |=> st_addr == $past(base_value) + $past(disp_ext)
        && st_data == $past(fp_src_value);
  endproperty
  a_disp_add: assert property (p_disp_add)
    else $error("Float dw store wrong");

  property p_idx_base_zero;
    @(posedge clock) disable iff (!reset_n)
    accept && is_fp_dx && base_zero |=> st_addr == $past(index_value);
  endproperty
  a_idx_base_zero: assert property (p_idx_base_zero)
    else $error("Indexed EA wrong");

  property p_word_store;
    @(posedge clock) disable iff (!reset_n)
    accept && is_fp_w && word_store_present |=> st_size == `SIED_SIZE_WORD
        && st_data == {32'h0, $past(fp_src_value[31:0])};
  endproperty
  a_word_store: assert property (p_word_store)
    else $error("Word store data wrong");

  property p_word_absent;
    @(posedge clock) disable iff (!reset_n)
    accept && is_fp_w && !word_store_present |=> unsupported_insn && !st_valid;
  endproperty
  a_word_absent: assert property (p_word_absent)
    else $error("Absent word store not refused");

  property p_fault_blocks_wb;
    @(posedge clock) disable iff (!reset_n)
    clock_en && state == sied_pkg::SIED_RESP && mem_resp_valid
        && (mem_align_int || mem_dsi_int) |=> !wb_valid;
  endproperty
  a_fault_blocks_wb: assert property (p_fault_blocks_wb)
    else $error("Update after fault");

  property p_wb_value;
    @(posedge clock) disable iff (!reset_n)
    wb_valid |-> wb_data == st_addr && wb_reg != 5'h00;
  endproperty
  a_wb_value: assert property (p_wb_value)
    else $error("Base update value wrong");

  property p_req_hold;
    @(posedge clock) disable iff (!reset_n)
    st_valid && !st_ready |=> st_valid && $stable(st_addr) && $stable(st_data);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("Store request dropped");

endmodule : sied_store_decode

// File: include/sied_cfg.svh
`ifndef SIED_CFG_SVH
`define SIED_CFG_SVH
// Instruction field positions, big-endian bit 0 is insn[31]
`define SIED_OP_HI 31
`define SIED_OP_LO 26
`define SIED_SRC_HI 25
`define SIED_SRC_LO 21
`define SIED_BASE_HI 20
`define SIED_BASE_LO 16
`define SIED_IDX_HI 15
`define SIED_IDX_LO 11
`define SIED_XO_HI 10
`define SIED_XO_LO 1
`define SIED_DISP_HI 15
`define SIED_DISP_LO 0
// Primary and extended opcodes
`define SIED_OP_XFORM 6'h1f
`define SIED_OP_FP_DISP 6'h36
`define SIED_OP_FP_DISP_UPD 6'h37
`define SIED_XO_INT_DW_IDX 10'h095
`define SIED_XO_FP_DW_IDX_UPD 10'h2f7
`define SIED_XO_FP_DW_IDX 10'h2d7
`define SIED_XO_FP_WORD_IDX 10'h3d7
// Store request sizes in bytes
`define SIED_SIZE_DW 4'h8
`define SIED_SIZE_WORD 4'h4
// Reset values
`define SIED_ADDR_RST 64'h0
`define SIED_DATA_RST 64'h0
`endif

// File: include/sied_pkg.sv
package sied_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    SIED_IDLE = 3'b001,
    SIED_REQ = 3'b010,
    SIED_RESP = 3'b100
  } sied_state_t;
endpackage : sied_pkg

// File: test/sied_mem_model.sv
`timescale 1ns/1ps
// Memory side model: takes one write, then answers with fault flags
module sied_mem_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic st_valid,
  input wire logic slow,
  input wire logic [1:0] flt,
  output logic st_ready,
  output logic mem_resp_valid,
  output logic mem_align_int,
  output logic mem_dsi_int
);
  logic [1:0] cnt;
  logic junk;
  // Flags mean nothing outside the response, so they toggle there
  assign mem_align_int = mem_resp_valid ? flt[0] : junk;
  assign mem_dsi_int = mem_resp_valid ? flt[1] : ~junk;
  // Ready after a fixed stall of three extra cycles when slow
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ready <= 1'b0;
      mem_resp_valid <= 1'b0;
      cnt <= 2'h0;
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
      mem_resp_valid <= st_valid && st_ready;
      st_ready <= 1'b0;
      cnt <= 2'h0;
      if (st_valid && !st_ready) begin
        cnt <= cnt + 2'h1;
        st_ready <= !slow || cnt == 2'h3;
      end
    end
  end
endmodule : sied_mem_model

// File: test/sied_store_decode_tb_top.sv
`timescale 1ns/1ps
module sied_store_decode_tb_top;
  logic clock, reset_n, insn_valid, impl_64bit, word_store_present, fp_src_single;
  logic slow, insn_ready, st_valid, st_ready, st_data_undefined, mem_resp_valid;
  logic mem_align_int, mem_dsi_int, wb_valid, illegal_insn, unsupported_insn;
  logic [1:0] flt;
  logic [3:0] st_size;
  logic [4:0] int_source_reg, fp_source_reg, base_reg_field, index_reg_field, wb_reg;
  logic [31:0] insn, seed, w, e;
  logic [63:0] int_src_value, fp_src_value, base_value, index_value;
  logic [63:0] st_addr, st_data, wb_data;
  int bad_count, comparisons, takes;
  logic [31:0] tmpl [9] = '{32'h7c00012a, 32'h7c0005ee, 32'h7c0005ae, 32'h7c0007ae,
    32'hd8000000, 32'hdc000000, 32'h7c00012b, 32'h7c000000, 32'hd0000000};
  logic [31:0] msk [9] = '{32'h03fff800, 32'h03fff801, 32'h03fff801, 32'h03fff801,
    32'h03ffffff, 32'h03ffffff, 32'h03fff800, 32'h03fff801, 32'h03ffffff};

  sied_store_decode #(.ADDR_W(64)) dut (.clock(clock), .reset_n(reset_n), .clock_en(1'b1),
    .insn_valid(insn_valid), .insn_ready(insn_ready), .insn(insn), .impl_64bit(impl_64bit),
    .word_store_present(word_store_present), .int_source_reg(int_source_reg),
    .fp_source_reg(fp_source_reg), .base_reg_field(base_reg_field),
    .index_reg_field(index_reg_field), .int_src_value(int_src_value),
    .fp_src_value(fp_src_value), .fp_src_single(fp_src_single), .base_value(base_value),
    .index_value(index_value), .st_valid(st_valid), .st_ready(st_ready), .st_addr(st_addr),
    .st_data(st_data), .st_size(st_size), .st_data_undefined(st_data_undefined),
    .mem_resp_valid(mem_resp_valid), .mem_align_int(mem_align_int),
    .mem_dsi_int(mem_dsi_int), .wb_valid(wb_valid), .wb_reg(wb_reg), .wb_data(wb_data),
    .illegal_insn(illegal_insn), .unsupported_insn(unsupported_insn));
  sied_mem_model mem (.clock(clock), .reset_n(reset_n), .st_valid(st_valid), .slow(slow),
    .flt(flt), .st_ready(st_ready), .mem_resp_valid(mem_resp_valid),
    .mem_align_int(mem_align_int), .mem_dsi_int(mem_dsi_int));

  // Linear feedback shift register, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction : rnd

  // Expected outcome; kind 0 store, 1 illegal, 2 unsupported
  function automatic void predict(output logic [1:0] kind, output logic [63:0] ea, dat,
      output logic [3:0] sz, output logic upd);
    logic [9:0] xo;
    logic [63:0] b;
    xo = insn[10:1];
    b = (insn[20:16] != 5'h0) ? base_value : 64'h0;
    kind = 2'h0;
    ea = b + index_value;
    dat = fp_src_value;
    sz = 4'h8;
    upd = 1'b0;
    if (insn[31:27] == 5'h1b) begin
      ea = b + {{48{insn[15]}}, insn[15:0]};
      upd = insn[26];
    end else if (insn[31:26] != 6'h1f) kind = 2'h2;
    else if (xo == 10'h095) begin
      dat = int_src_value;
      kind = insn[0] ? 2'h2 : (impl_64bit ? 2'h0 : 2'h1);
    end else if (xo == 10'h3d7) begin
      dat = {32'h0, fp_src_value[31:0]};
      sz = 4'h4;
      kind = word_store_present ? 2'h0 : 2'h2;
    end else if (xo == 10'h2f7) upd = 1'b1;
    else if (xo != 10'h2d7) kind = 2'h2;
  endfunction : predict

  task automatic check(input logic ok, input string msg);
    comparisons++;
    // Unknown counts as a miss, so an X result never slips through
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  // One instruction with its environment bits, through to writeback
  task automatic run_one(input logic [31:0] wd, input logic [31:0] ev);
    logic [1:0] kind;
    logic [63:0] ea, dat;
    logic [3:0] sz;
    logic upd;
    int n;
    @(posedge clock);
    insn <= wd;
    insn_valid <= 1'b1;
    {impl_64bit, word_store_present, fp_src_single, slow, flt} <= ev[5:0];
    base_value <= {rnd(), rnd()};
    index_value <= {rnd(), rnd()};
    int_src_value <= {rnd(), rnd()};
    fp_src_value <= {rnd(), rnd()};
    #1;
    predict(kind, ea, dat, sz, upd);
    takes = 0;
    check(base_reg_field === wd[20:16], "base field");
    check(index_reg_field === wd[15:11], "index field");
    check(fp_source_reg === wd[25:21], "float source field");
    check(int_source_reg === wd[25:21], "int source field");
    @(posedge clock);
    insn_valid <= 1'b0;
    #1;
    check(illegal_insn === (kind == 2'h1), "illegal pulse");
    check(unsupported_insn === (kind == 2'h2), "unsupported pulse");
    check(st_valid === (kind == 2'h0), "store request");
    if (kind == 2'h0) begin
      check(st_addr === ea && st_data === dat, "store content");
      check(st_size === sz, "store size");
      check(st_data_undefined === (sz == 4'h4 && fp_src_single), "undef flag");
      n = 0;
      while (mem_resp_valid !== 1'b1 && n < 20) begin
        @(posedge clock);
        #1;
        n++;
      end
      @(posedge clock);
      #1;
      check(wb_valid === (upd && wd[20:16] != 5'h0 && flt == 2'h0), "writeback");
      if (wb_valid === 1'b1) begin
        check(wb_reg === wd[20:16] && wb_data === ea, "wb value");
      end
    end else begin
      // Refusal pulses must last exactly one cycle
      @(posedge clock);
      #1;
      check(illegal_insn === 1'b0 && unsupported_insn === 1'b0, "pulse too long");
    end
    check(takes == int'(kind == 2'h0) && insn_ready === 1'b1, "request count");
  endtask : run_one

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // Write requests taken by memory, exactly one per store
  always @(posedge clock) if (st_valid === 1'b1 && st_ready === 1'b1) takes++;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Corner sweep of every encoding, then random traffic
  initial begin
    {reset_n, insn_valid, fp_src_single, slow, flt, insn, bad_count, comparisons} = '0;
    {impl_64bit, word_store_present, takes, seed} = {2'b11, 32'd0, 32'd74963};
    {int_src_value, fp_src_value, base_value, index_value} = '0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    for (int k = 0; k < 336; k++) begin
      e = rnd();
      w = tmpl[k % 9] | (rnd() & msk[k % 9]);
      if (k < 36) begin
        e = {26'h0, k < 18, k < 18, k[0], k[1], 2'(k / 9)};
        if ((k / 3) % 2 == 1) w[20:16] = 5'h0;
      end else begin
        e[5:4] = e[5:4] | e[7:6];
        e[1:0] = e[1:0] & {2{e[8]}};
        if (e[9] && e[10]) w[20:16] = 5'h0;
      end
      run_one(w, e);
      if (k == 35 || k == 335) $display("test %s done", (k == 35) ? "corners" : "random");
    end
    summarize();
  end

  // Cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : sied_store_decode_tb_top
